// File: verilog/cpu_xchg_pkg.sv
// shared constants and types for the exchange / exit control block
package cpu_xchg_pkg;
   localparam int AW = 18;
   localparam int WW = 60;
   localparam int NREG = 8;
   localparam logic [2:0] LAST_LOAD_IDX = 3'h5;
   // stop selector enable bits
   localparam int EM_ADDR_POS = 12;
   localparam int EM_INF_POS = 13;
   localparam int EM_INDEF_POS = 14;
   // exchange package: 16 words, word k<8 = {pad, header, pointer k, index k}
   localparam logic [3:0] XJ_LAST_WORD = 4'hf;
   localparam logic [3:0] XJ_FIRST_XWORD = 4'h8;
   localparam int PK_PAD_W = 6;
   localparam logic [3:0] HDR_P = 4'h0;
   localparam logic [3:0] HDR_RA = 4'h1;
   localparam logic [3:0] HDR_FL = 4'h2;
   localparam logic [3:0] HDR_EM = 4'h3;
   // exit word: {stop opcode, exit code, P, zero fill}
   localparam logic [5:0] STOP_OPCODE = 6'h00;
   localparam int EX_FILL_W = 30;
   localparam logic [17:0] EXIT_REL_ADDR = 18'h00000;
   localparam logic [17:0] P_RESET = 18'h00000;
   localparam logic [17:0] P_STEP = 18'h00001;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_XRD = 5'h02,
      ST_XWR = 5'h04,
      ST_EXIT = 5'h08,
      ST_HALT = 5'h10
   } ctl_state_t;
   typedef enum logic [2:0] {
      K_LD = 3'h0,
      K_ST = 3'h1,
      K_FETCH = 3'h2,
      K_XRD = 3'h3,
      K_XWR = 3'h4,
      K_EXIT = 3'h5
   } mem_kind_t;
   typedef enum logic [1:0] {
      INC_CONST = 2'h0,
      INC_ADD_B = 2'h1,
      INC_SUB_B = 2'h2
   } inc_form_t;
   typedef enum logic [1:0] {
      RK_A = 2'h0,
      RK_B = 2'h1,
      RK_X = 2'h2
   } reg_kind_t;
endpackage

// File: verilog/mem_req_if.sv
// request / answer bundle between the control core and the memory port
`timescale 1ns/1ps
`default_nettype none
interface mem_req_if;
   logic req;
   logic we;
   logic abs_addr;
   logic chk;
   logic [17:0] addr;
   logic [59:0] wdata;
   logic [17:0] ra;
   logic [17:0] fl;
   logic ack;
   logic oob;
   logic [59:0] rdata;
   modport core (output req, we, abs_addr, chk, addr, wdata, ra, fl, input ack, oob, rdata);
   modport port (input req, we, abs_addr, chk, addr, wdata, ra, fl, output ack, oob, rdata);
endinterface
`default_nettype wire

// File: verilog/incr_adder.sv
// 18-bit ones-complement add / subtract for the increment path
`timescale 1ns/1ps
`default_nettype none
module incr_adder
   import cpu_xchg_pkg::*;
(
   input wire logic [17:0] a_in,
   input wire logic [17:0] b_in,
   input wire logic sub_in,
   output logic [17:0] sum_out
);
   logic [17:0] b_eff;
   logic [18:0] raw;
   // subtract by complement, end-around carry
   assign b_eff = sub_in ? ~b_in : b_in;
   assign raw = {1'b0, a_in} + {1'b0, b_eff};
   assign sum_out = raw[17:0] + {17'h00000, raw[18]};
endmodule
`default_nettype wire

// File: verilog/mem_port.sv
// relocation, bounds check and central memory handshake
`timescale 1ns/1ps
`default_nettype none
module mem_port
   import cpu_xchg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   mem_req_if.port m,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [17:0] mem_addr_out,
   output logic [59:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [59:0] mem_rdata_in
);
   logic busy;
   logic ack;
   logic oob;
   logic [59:0] rdata;
   wire [17:0] phys = m.abs_addr ? m.addr : m.addr + m.ra;
   wire over = m.chk && (m.addr >= m.fl);
   wire take = m.req && !busy && !ack;
   assign m.ack = ack;
   assign m.oob = oob;
   assign m.rdata = rdata;
   // accept one reference at a time, refuse out-of-window ones
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         busy <= 1'b0;
         ack <= 1'b0;
         oob <= 1'b0;
         rdata <= '0;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= '0;
         mem_wdata_out <= '0;
      end
      else
      begin
         ack <= take && over;
         if (take)
         begin
            oob <= over;
            busy <= !over;
            mem_req_out <= !over;
            mem_we_out <= m.we;
            mem_addr_out <= phys;
            mem_wdata_out <= m.wdata;
            rdata <= '0;
         end
         else if (busy && mem_ack_in)
         begin
            busy <= 1'b0;
            mem_req_out <= 1'b0;
            ack <= 1'b1;
            rdata <= mem_rdata_in;
         end
      end
   end
   a_reloc_addr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take && !over && !m.abs_addr)
      |=> mem_req_out && mem_addr_out == $past(m.addr) + $past(m.ra))
      else $error("reference not relocated");
   a_bounds_refuse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take && over) |=> ack && oob && !mem_req_out)
      else $error("out-of-window reference reached memory");
endmodule
`default_nettype wire

// File: verilog/cpu_exchange_exit_control.sv
// central processor program control, register linkage and exchange logic
`timescale 1ns/1ps
`default_nettype none
// Function
// - pointers one-five changed start operand load
// - pointers six-seven changed store operand word
// - pointer zero, operand zero have no linkage
// - index regs no traffic, index zero reads zero
// - increment: constant, add index, subtract index
// - counter steps after whole word extracted
// - branch loads target, return saves counter+1
// - after branch start at top parcel
// - peripheral exchange gives sixteen-word package address
// - package holds counter, base, length, selector, regs
// - load new context, store old, same words
// - exchange pointer loads start no memory traffic
// - base added to every program reference
// - out-of-window reference stops when enabled
// - selector bits choose address, infinite, indefinite stops
// - stop immediately when enabled condition seen
// - exit writes stop word at zero, halts
// - exchange taken at next convenient breakpoint
module cpu_exchange_exit_control
   import cpu_xchg_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic xj_req_in,
   input wire logic [17:0] xj_base_in,
   output logic [17:0] p_out,
   output logic halted_out,
   input wire logic inc_valid_in,
   input wire inc_form_t inc_form_in,
   input wire reg_kind_t inc_dst_kind_in,
   input wire logic [2:0] inc_dst_idx_in,
   input wire reg_kind_t inc_src_kind_in,
   input wire logic [2:0] inc_src_idx_in,
   input wire logic [2:0] inc_b_idx_in,
   input wire logic [17:0] inc_k_in,
   output logic issue_ready_out,
   input wire logic x_wr_valid_in,
   input wire logic [2:0] x_wr_idx_in,
   input wire logic [59:0] x_wr_data_in,
   input wire logic [2:0] x_rd_idx_in,
   output logic x_rd_ready_out,
   output logic [59:0] x_rd_data_out,
   input wire logic word_done_in,
   input wire logic branch_in,
   input wire logic return_jump_in,
   input wire logic [17:0] branch_target_in,
   output logic [17:0] ret_addr_out,
   output logic ret_valid_out,
   output logic top_parcel_out,
   input wire logic fetch_req_in,
   output logic fetch_ack_out,
   output logic [59:0] fetch_word_out,
   input wire logic stop_in,
   input wire logic infinite_in,
   input wire logic indefinite_in,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [17:0] mem_addr_out,
   output logic [59:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic [59:0] mem_rdata_in
);
   ctl_state_t state;
   ctl_state_t next_state;
   logic [17:0] ar [NREG];
   logic [17:0] br [NREG];
   logic [59:0] xr [NREG];
   logic [17:0] p;
   logic [17:0] ra;
   logic [17:0] fl;
   logic [17:0] em;
   logic [7:1] pending;
   logic xj_pend;
   logic [17:0] xj_base;
   logic [3:0] step;
   logic [59:0] xj_word;
   logic [5:0] exit_code;
   logic mem_busy;
   mem_kind_t cur_kind;
   logic [2:0] cur_idx;
   logic mwe;
   logic mabs;
   logic mchk;
   logic [17:0] maddr;
   logic [59:0] mwdata;
   logic [17:0] inc_result;
   logic [7:0] a_change;
   logic [7:0] ld_done;
   mem_req_if m ();

   ////////////////////////////////////////////////////////////////////////////
   // memory port and increment adder
   mem_port u_port (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .m(m.port),
      .mem_req_out(mem_req_out),
      .mem_we_out(mem_we_out),
      .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out),
      .mem_ack_in(mem_ack_in),
      .mem_rdata_in(mem_rdata_in)
   );
   assign m.req = mem_busy;
   assign m.we = mwe;
   assign m.abs_addr = mabs;
   assign m.chk = mchk;
   assign m.addr = maddr;
   assign m.wdata = mwdata;
   assign m.ra = ra;
   assign m.fl = fl;

   // operand select for the three increment forms
   wire [17:0] src_val = (inc_src_kind_in == RK_A) ? ar[inc_src_idx_in] :
                         (inc_src_kind_in == RK_B) ? br[inc_src_idx_in] :
                         xr[inc_src_idx_in][17:0];
   wire [17:0] inc_b_val = (inc_form_in == INC_CONST) ? inc_k_in : br[inc_b_idx_in];
   incr_adder u_inc (
      .a_in(src_val),
      .b_in(inc_b_val),
      .sub_in(inc_form_in == INC_SUB_B),
      .sum_out(inc_result)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode of events
   wire in_run = (state == ST_RUN);
   wire run_ack = m.ack && (cur_kind == K_LD || cur_kind == K_ST || cur_kind == K_FETCH);
   wire oob_hit = run_ack && m.oob;
   wire [2:0] cond = {indefinite_in & em[EM_INDEF_POS],
                      infinite_in & em[EM_INF_POS],
                      oob_hit & em[EM_ADDR_POS]};
   wire exit_now = in_run && (|cond || stop_in);
   wire any_pending = |pending;
   wire xj_take = xj_pend && !exit_now && !mem_busy && !any_pending &&
                  (in_run || state == ST_HALT);
   wire inc_go = inc_valid_in && issue_ready_out;
   wire xrd_done = m.ack && cur_kind == K_XRD;
   wire xwr_done = m.ack && cur_kind == K_XWR;
   wire exit_done = m.ack && cur_kind == K_EXIT;
   wire xj_last = xwr_done && step == XJ_LAST_WORD;
   wire run_free = in_run && !exit_now && !mem_busy && !xj_take;
   wire issue_op = run_free && any_pending;
   wire issue_fetch = run_free && !any_pending && fetch_req_in;
   wire issue_xj = !mem_busy && (state == ST_XRD || state == ST_XWR);
   wire issue_exit = !mem_busy && state == ST_EXIT;
   assign issue_ready_out = in_run && !xj_take && !exit_now;
   assign halted_out = (state == ST_HALT);
   assign p_out = p;
   assign fetch_ack_out = m.ack && cur_kind == K_FETCH;
   assign fetch_word_out = m.rdata;
   assign x_rd_ready_out = !((x_rd_idx_in != 3'h0) && (x_rd_idx_in <= LAST_LOAD_IDX) &&
                             pending[x_rd_idx_in]);

   // lowest pending pointer wins the port
   function automatic logic [2:0] pick(input logic [7:1] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 1; i--)
         if (v[i])
            r = 3'(i);
      return r;
   endfunction
   wire [2:0] op_idx = pick(pending);

   // outgoing package word for the current step
   wire [2:0] lo_idx = step[2:0];
   wire [17:0] hdr_old = (step == HDR_P) ? p : (step == HDR_RA) ? ra :
                         (step == HDR_FL) ? fl : (step == HDR_EM) ? em : '0;
   wire [59:0] old_word = (step >= XJ_FIRST_XWORD) ? xr[lo_idx] :
                          {{PK_PAD_W{1'b0}}, hdr_old, ar[lo_idx], br[lo_idx]};
   wire [17:0] hdr_new = xj_word[53:36];
   wire [59:0] exit_word = {STOP_OPCODE, exit_code, p, {EX_FILL_W{1'b0}}};

   ////////////////////////////////////////////////////////////////////////////
   // control sequence
   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (exit_now)
               next_state = ST_EXIT;
            else if (xj_take)
               next_state = ST_XRD;
         ST_XRD:
            if (xrd_done)
               next_state = ST_XWR;
         ST_XWR:
            if (xj_last)
               next_state = ST_RUN;
            else if (xwr_done)
               next_state = ST_XRD;
         ST_EXIT:
            if (exit_done)
               next_state = ST_HALT;
         ST_HALT:
            if (xj_take)
               next_state = ST_XRD;
         default:
            next_state = ST_HALT;
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         state <= ST_HALT;
      else
         state <= next_state;
   end

   // exchange request is sticky; a new request beats the clear
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         xj_pend <= 1'b0;
         xj_base <= '0;
         step <= '0;
         xj_word <= '0;
         exit_code <= '0;
      end
      else
      begin
         xj_pend <= xj_req_in | (xj_pend & ~xj_take);
         if (xj_req_in)
            xj_base <= xj_base_in;
         if (xj_take)
            step <= '0;
         else if (xwr_done)
            step <= step + 4'h1;
         if (xrd_done)
            xj_word <= m.rdata;
         if (exit_now)
            exit_code <= {3'h0, cond};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory request holder: stands until the port answers
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         mem_busy <= 1'b0;
         cur_kind <= K_FETCH;
         cur_idx <= '0;
         mwe <= 1'b0;
         mabs <= 1'b0;
         mchk <= 1'b0;
         maddr <= '0;
         mwdata <= '0;
      end
      else if (m.ack)
         mem_busy <= 1'b0;
      else if (issue_op)
      begin
         mem_busy <= 1'b1;
         cur_idx <= op_idx;
         cur_kind <= (op_idx <= LAST_LOAD_IDX) ? K_LD : K_ST;
         mwe <= (op_idx > LAST_LOAD_IDX);
         mabs <= 1'b0;
         mchk <= 1'b1;
         maddr <= ar[op_idx];
         mwdata <= xr[op_idx];
      end
      else if (issue_fetch)
      begin
         mem_busy <= 1'b1;
         cur_kind <= K_FETCH;
         mwe <= 1'b0;
         mabs <= 1'b0;
         mchk <= 1'b1;
         maddr <= p;
      end
      else if (issue_xj)
      begin
         mem_busy <= 1'b1;
         cur_kind <= (state == ST_XRD) ? K_XRD : K_XWR;
         mwe <= (state == ST_XWR);
         mabs <= 1'b1;
         mchk <= 1'b0;
         maddr <= xj_base + {14'h0000, step};
         mwdata <= old_word;
      end
      else if (issue_exit)
      begin
         mem_busy <= 1'b1;
         cur_kind <= K_EXIT;
         mwe <= 1'b1;
         mabs <= 1'b0;
         mchk <= 1'b0;
         maddr <= EXIT_REL_ADDR;
         mwdata <= exit_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter, base, length, selector
   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         p <= P_RESET;
         ra <= '0;
         fl <= '0;
         em <= '0;
         ret_addr_out <= '0;
         ret_valid_out <= 1'b0;
         top_parcel_out <= 1'b0;
      end
      else
      begin
         ret_valid_out <= in_run && !exit_now && branch_in && return_jump_in;
         top_parcel_out <= (in_run && !exit_now && branch_in) || xj_last;
         if (exit_done)
            p <= P_RESET;
         else if (xwr_done && step == HDR_P)
            p <= hdr_new;
         else if (in_run && !exit_now && branch_in)
         begin
            p <= branch_target_in;
            if (return_jump_in)
               ret_addr_out <= p + P_STEP;
         end
         else if (in_run && !exit_now && word_done_in)
            p <= p + P_STEP;
         if (xwr_done && step == HDR_RA)
            ra <= hdr_new;
         if (xwr_done && step == HDR_FL)
            fl <= hdr_new;
         if (xwr_done && step == HDR_EM)
            em <= hdr_new;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         x_rd_data_out <= '0;
      else
         x_rd_data_out <= xr[x_rd_idx_in];
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-entry pointer, index and operand registers
   for (genvar gi = 0; gi < NREG; gi++)
   begin : g_reg
      wire a_wr = inc_go && inc_dst_kind_in == RK_A && inc_dst_idx_in == 3'(gi);
      wire b_wr = inc_go && inc_dst_kind_in == RK_B && inc_dst_idx_in == 3'(gi);
      wire lo_commit = xwr_done && step == 4'(gi);
      wire x_commit = xwr_done && step == 4'(gi + NREG);
      assign ld_done[gi] = run_ack && cur_kind == K_LD && cur_idx == 3'(gi);
      // only a real change of pointers one to seven links to memory
      assign a_change[gi] = (gi != 0) && a_wr && inc_result != ar[gi];
      always_ff @(posedge clk_sys_in or posedge sys_rst_in)
      begin
         if (sys_rst_in)
         begin
            ar[gi] <= '0;
            xr[gi] <= '0;
         end
         else
         begin
            if (lo_commit)
               ar[gi] <= xj_word[35:18];
            else if (a_wr)
               ar[gi] <= inc_result;
            if (x_commit)
               xr[gi] <= xj_word;
            else if (x_wr_valid_in && x_wr_idx_in == 3'(gi))
               xr[gi] <= x_wr_data_in;
            else if (ld_done[gi])
               xr[gi] <= m.rdata;
         end
      end
      if (gi == 0)
      begin : g_zero
         assign br[gi] = '0;
      end
      else
      begin : g_live
         always_ff @(posedge clk_sys_in or posedge sys_rst_in)
         begin
            if (sys_rst_in)
               br[gi] <= '0;
            else if (lo_commit)
               br[gi] <= xj_word[17:0];
            else if (b_wr)
               br[gi] <= inc_result;
         end
         // new change beats completion; an answer for a stale address keeps the link
         always_ff @(posedge clk_sys_in or posedge sys_rst_in)
         begin
            if (sys_rst_in)
               pending[gi] <= 1'b0;
            else if (!in_run || exit_now)
               pending[gi] <= 1'b0;
            else
               pending[gi] <= a_change[gi] |
                              (pending[gi] & ~(run_ack && cur_idx == 3'(gi) &&
                                               maddr == ar[gi]));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_link_start: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (a_change[inc_dst_idx_in] && !exit_now) |=> pending[$past(inc_dst_idx_in)])
      else $error("pointer change did not start a reference");
   a_scratch_quiet: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (inc_go && inc_dst_kind_in == RK_A && inc_dst_idx_in == 3'h0)
      |=> ((pending & ~$past(pending)) == 7'h00))
      else $error("scratch pointer started memory traffic");
   a_zero_index: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (inc_go && inc_form_in != INC_CONST && inc_b_idx_in == 3'h0) |-> inc_b_val == 18'h00000)
      else $error("index zero not zero");
   a_pc_step: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (in_run && !exit_now && !branch_in && word_done_in && !xwr_done)
      |=> p == $past(p) + P_STEP)
      else $error("counter did not step");
   a_ret_save: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (in_run && !exit_now && branch_in && return_jump_in)
      |=> ret_valid_out && ret_addr_out == $past(p) + P_STEP && p == $past(branch_target_in)
      && top_parcel_out)
      else $error("return jump mishandled");
   a_xj_no_link: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state == ST_XRD || state == ST_XWR) |-> pending == 7'h00 && !issue_op)
      else $error("linkage active during exchange");
   a_exit_word: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (mem_busy && cur_kind == K_EXIT)
      |-> maddr == EXIT_REL_ADDR && !mabs && mwe && mwdata[47:30] == p)
      else $error("exit word malformed");
   a_exit_halt: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      exit_done |=> halted_out && p == P_RESET)
      else $error("exit did not halt at zero");
   a_exit_fast: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      exit_now |=> state == ST_EXIT && !issue_ready_out)
      else $error("exit delayed");
   a_ld_wait: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (a_change[inc_dst_idx_in] && inc_dst_idx_in <= LAST_LOAD_IDX && !exit_now)
      |=> (x_rd_idx_in != $past(inc_dst_idx_in) || !x_rd_ready_out))
      else $error("load operand readable too early");
   c_exchange: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) xj_last);
   c_addr_exit: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      exit_now && cond[0]);
   c_load_done: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in) |ld_done);
endmodule
`default_nettype wire

// File: sim/cpu_mem_model.sv
// central memory model behind the block's memory port
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
   input wire logic clk_sys_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [17:0] addr_in,
   input wire logic [59:0] wdata_in,
   output logic ack_out,
   output logic [59:0] rdata_out
);
   logic [59:0] mem [0:255];
   logic [1:0] wait_cnt;
   // each word starts out holding its own address
   initial
   begin
      for (int i = 0; i < 256; i++) mem[i] = 60'(i);
      ack_out = 1'b0;
      rdata_out = 60'h0;
      wait_cnt = 2'h0;
   end
   // answer after three cycles; read data scrambles when idle
   always @(posedge clk_sys_in)
   begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out)
      begin
         wait_cnt <= wait_cnt + 2'h1;
         if (wait_cnt == 2'h2)
         begin
            ack_out <= 1'b1;
            wait_cnt <= 2'h0;
            if (we_in) mem[addr_in[7:0]] <= wdata_in;
            else rdata_out <= mem[addr_in[7:0]];
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/cpu_exchange_exit_control_tb.sv
// self-checking bench for the exchange and exit control block
`timescale 1ns/1ps
`default_nettype none
module cpu_exchange_exit_control_tb;
   import cpu_xchg_pkg::*;
   typedef struct {inc_form_t f; logic [2:0] d; reg_kind_t s; logic [2:0] si; logic [2:0] b;
      logic [17:0] k; logic [59:0] e;} row_t;
   logic clk_sys_in, sys_rst_in, xj_req_in, inc_valid_in, x_wr_valid_in, x_rd_ready_out;
   logic word_done_in, branch_in, return_jump_in, fetch_req_in, stop_in, infinite_in;
   logic indefinite_in, halted_out, issue_ready_out, ret_valid_out, top_parcel_out;
   logic fetch_ack_out, mem_req_out, mem_we_out, mem_ack_in;
   logic [2:0] inc_dst_idx_in, inc_src_idx_in, inc_b_idx_in, x_wr_idx_in, x_rd_idx_in;
   logic [17:0] xj_base_in, p_out, inc_k_in, branch_target_in, ret_addr_out, mem_addr_out;
   logic [59:0] x_wr_data_in, x_rd_data_out, fetch_word_out, mem_wdata_out, mem_rdata_in;
   inc_form_t inc_form_in;
   reg_kind_t inc_dst_kind_in, inc_src_kind_in;
   int num_errors = 0;
   int n_checks = 0;
   // increments: form, target, source kind and number, index, constant, loaded word
   row_t rows [5] = '{'{INC_CONST, 3'h1, RK_A, 3'h1, 3'h0, 18'h00001, 60'h86},
      '{INC_ADD_B, 3'h2, RK_A, 3'h1, 3'h1, 18'h0, 60'h88},
      '{INC_SUB_B, 3'h3, RK_A, 3'h1, 3'h2, 18'h0, 60'h83},
      '{INC_CONST, 3'h5, RK_B, 3'h1, 3'h0, 18'h3fffe, 60'h81},
      '{INC_ADD_B, 3'h4, RK_B, 3'h2, 3'h1, 18'h0, 60'h85}};
   cpu_exchange_exit_control dut (.*);
   cpu_mem_model mem_m (.clk_sys_in(clk_sys_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
      .rdata_out(mem_rdata_in));
   // 100 ns system clock
   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic chk(input string nm, input logic [59:0] e, input logic [59:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one increment, then wait out the linked reference
   task automatic inc(input row_t r);
      tick();
      inc_valid_in <= 1'b1;
      inc_form_in <= r.f;
      inc_src_kind_in <= r.s;
      inc_dst_idx_in <= r.d;
      inc_src_idx_in <= r.si;
      inc_b_idx_in <= r.b;
      inc_k_in <= r.k;
      x_rd_idx_in <= r.d;
      tick();
      inc_valid_in <= 1'b0;
      tick(2);
      @(negedge clk_sys_in);
      for (int i = 0; i < 50 && x_rd_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
      tick(2);
      @(negedge clk_sys_in);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      #2000000;
      num_errors++;
      stop_test();
   end
   initial
   begin
      sys_rst_in = 1'b1;
      {xj_req_in, inc_valid_in, x_wr_valid_in, word_done_in, branch_in, return_jump_in} = '0;
      {fetch_req_in, stop_in, infinite_in, indefinite_in, x_wr_idx_in, x_rd_idx_in} = '0;
      {inc_dst_idx_in, inc_src_idx_in, inc_b_idx_in, inc_k_in, branch_target_in} = '0;
      x_wr_data_in = 60'h0;
      xj_base_in = 18'h00040;
      inc_form_in = INC_CONST;
      inc_dst_kind_in = RK_A;
      inc_src_kind_in = RK_A;
      tick(20);
      sys_rst_in <= 1'b0;
      // package: counter, base, window with index two, address stop
      mem_m.mem[8'h40] = {6'h0, 18'h10, 36'h0};
      mem_m.mem[8'h41] = {6'h0, 18'h80, 18'h5, 18'h2};
      mem_m.mem[8'h42] = {6'h0, 18'h20, 18'h0, 18'h3};
      mem_m.mem[8'h43] = {6'h0, 18'h01000, 36'h0};
      @(negedge clk_sys_in);
      chk("reset p", 60'h0, 60'(p_out));
      tick();
      xj_req_in <= 1'b1;
      tick();
      xj_req_in <= 1'b0;
      for (int i = 0; i < 2000 && top_parcel_out !== 1'b1; i++) @(negedge clk_sys_in);
      chk("xj p", 60'h10, 60'(p_out));
      chk("old word0", 60'h0, mem_m.mem[8'h40]);
      chk("old x1", 60'h0, mem_m.mem[8'h49]);
      tick();
      x_rd_idx_in <= 3'h1;
      tick(2);
      @(negedge clk_sys_in);
      chk("xj x1", 60'h49, x_rd_data_out);
      foreach (rows[i])
      begin
         inc(rows[i]);
         chk("load", rows[i].e, x_rd_data_out);
      end
      tick();
      x_wr_valid_in <= 1'b1;
      x_wr_idx_in <= 3'h6;
      x_wr_data_in <= 60'h5a5;
      tick();
      x_wr_valid_in <= 1'b0;
      inc('{INC_CONST, 3'h6, RK_A, 3'h0, 3'h0, 18'h10, 60'h0});
      for (int i = 0; i < 50 && mem_m.mem[8'h90] !== 60'h5a5; i++) tick();
      chk("store", 60'h5a5, mem_m.mem[8'h90]);
      inc('{INC_CONST, 3'h0, RK_A, 3'h0, 3'h0, 18'h7, 60'h0});
      chk("scratch x0", 60'h48, x_rd_data_out);
      tick();
      inc_dst_kind_in <= RK_B;
      inc('{INC_ADD_B, 3'h0, RK_X, 3'h1, 3'h1, 18'h0, 60'h0});
      tick();
      inc_dst_kind_in <= RK_A;
      inc('{INC_ADD_B, 3'h3, RK_A, 3'h1, 3'h0, 18'h0, 60'h0});
      chk("b0 zero", 60'h86, x_rd_data_out);
      tick();
      word_done_in <= 1'b1;
      tick();
      word_done_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("p step", 60'h11, 60'(p_out));
      tick();
      branch_in <= 1'b1;
      return_jump_in <= 1'b1;
      branch_target_in <= 18'h18;
      tick();
      branch_in <= 1'b0;
      return_jump_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("branch p", 60'h18, 60'(p_out));
      chk("ret", 60'h12, 60'(ret_addr_out));
      chk("top", 60'h1, 60'(top_parcel_out));
      chk("ret valid", 60'h1, 60'(ret_valid_out));
      tick();
      fetch_req_in <= 1'b1;
      for (int i = 0; i < 50 && fetch_ack_out !== 1'b1; i++) @(negedge clk_sys_in);
      chk("fetch", 60'h98, fetch_word_out);
      tick();
      fetch_req_in <= 1'b0;
      inc('{INC_CONST, 3'h4, RK_B, 3'h0, 3'h0, 18'h25, 60'h0});
      for (int i = 0; i < 100 && halted_out !== 1'b1; i++) @(negedge clk_sys_in);
      chk("exit p", 60'h0, 60'(p_out));
      chk("exit word", {6'h0, 6'h01, 18'h18, 30'h0}, mem_m.mem[8'h80]);
      chk("halted", 60'h1, 60'(halted_out));
      chk("refuse", 60'h0, 60'(issue_ready_out));
      stop_test();
   end
endmodule
`default_nettype wire
